/* design/clk_switch_pkg.sv */
// constants and types shared by the cpu clock source switch
package clk_switch_pkg;

  // ==========================================================
  // register byte addresses
  localparam logic [3:0] ADDR_PROC_CLK_CTRL = 4'h0;
  localparam logic [3:0] ADDR_PROT_CMD      = 4'h4;
  localparam logic [3:0] ADDR_INT_OSC_MODE  = 4'h8;
  localparam logic [3:0] ADDR_STATUS        = 4'hC;

  // ==========================================================
  // processor_clock_ctrl field positions; POS_INT_HALT is in the internal osc mode register
  localparam int POS_DIV_LO     = 0;
  localparam int POS_DIV_HI     = 2;
  localparam int POS_SRC_SEL    = 3;
  localparam int POS_SUB_ACTIVE = 4;
  localparam int POS_MAIN_STOP  = 6;
  localparam int POS_INT_HALT   = 0;

  // ==========================================================
  // reset values, limits and bus response codes
  localparam logic [7:0] PCC_RESET      = 8'h03;
  localparam logic [7:0] INT_OSC_RESET  = 8'h00;
  localparam logic [2:0] DIV_MAX_SEL    = 3'h4;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // synchroniser depth for the subclock tick
  localparam int SYNC_STAGES = 2;

  typedef enum logic [1:0] {SRC_MAIN, SRC_TO_SUB, SRC_SUB, SRC_TO_MAIN} src_state_e;

endpackage

/* design/cpu_clock_source_switch.sv */
// cpu clock source switch with axi4-lite registers
`timescale 1ns/1ps
module cpu_clock_source_switch
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [3:0]  s_axi_awaddr_in,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  // axi4-lite write response
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  output logic [1:0]       s_axi_bresp_out,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  input  wire logic [3:0]  s_axi_araddr_in,
  // axi4-lite read data
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  // clock sources and status
  input  wire logic        sub_clock_in,
  input  wire logic        cpu_on_int_osc_in,
  // clock control outputs
  output logic             cpu_on_sub_clock_out,
  output logic             main_osc_enable_out,
  output logic             int_osc_enable_out,
  output logic [4:0]       clk_divide_out
);
  import clk_switch_pkg::*;

  typedef struct packed
  {
    logic       aw_got;
    logic [3:0] aw_addr;
    logic       w_got;
    logic [7:0] w_byte;
    logic       w_lane0;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic       unlocked;
    logic [2:0] div_sel;
    logic       src_sel;
    logic       main_stop;
    logic       int_halt;
    src_state_e src;
    logic [4:0] divide;
    logic       int_osc_sync;
    logic       int_osc;
    logic       aw_rdy;
    logic       w_rdy;
    logic       ar_rdy;
    logic       sub_flag;
    logic       main_en;
    logic       int_en;
  } state_s;

  state_s     st_ff;
  state_s     nxt_st;
  logic       sub_tick;
  logic [7:0] pcc_view;

  edge_sync u_sub_sync
  (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .level_in  (sub_clock_in),
    .rise_out  (sub_tick)
  );

  // ==========================================================
  // register views
  always_comb
  begin
    pcc_view                 = 8'h00;
    pcc_view[POS_DIV_HI:0]   = st_ff.div_sel;
    pcc_view[POS_SRC_SEL]    = st_ff.src_sel;
    pcc_view[POS_SUB_ACTIVE] = st_ff.sub_flag;
    pcc_view[POS_MAIN_STOP]  = st_ff.main_stop;
  end

  // ==========================================================
  // bus and control
  always_comb
  begin
    nxt_st              = st_ff;
    nxt_st.int_osc_sync = cpu_on_int_osc_in;
    nxt_st.int_osc      = st_ff.int_osc_sync;

    // write channels taken independently
    if (s_axi_awvalid_in && !st_ff.aw_got)
    begin
      nxt_st.aw_got  = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && !st_ff.w_got)
    begin
      nxt_st.w_got   = 1'b1;
      nxt_st.w_byte  = s_axi_wdata_in[7:0];
      nxt_st.w_lane0 = s_axi_wstrb_in[0];
    end

    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid)
    begin
      nxt_st.aw_got   = 1'b0;
      nxt_st.w_got    = 1'b0;
      nxt_st.bvalid   = 1'b1;
      nxt_st.bresp    = RESP_OKAY;
      nxt_st.unlocked = 1'b0;
      if (st_ff.aw_addr == ADDR_PROT_CMD)
      begin
        nxt_st.unlocked = st_ff.w_lane0;
      end
      else if (st_ff.aw_addr == ADDR_PROC_CLK_CTRL)
      begin
        if (st_ff.unlocked && st_ff.w_lane0)
        begin
          nxt_st.div_sel   = st_ff.w_byte[POS_DIV_HI:0];
          nxt_st.src_sel   = st_ff.w_byte[POS_SRC_SEL];
          nxt_st.main_stop = st_ff.w_byte[POS_MAIN_STOP];
        end
      end
      else if (st_ff.aw_addr == ADDR_INT_OSC_MODE)
      begin
        if (st_ff.w_lane0)
        begin
          nxt_st.int_halt = st_ff.w_byte[POS_INT_HALT];
        end
      end
      else if (st_ff.aw_addr != ADDR_STATUS)
      begin
        nxt_st.bresp = RESP_SLVERR;
      end
    end
    if (st_ff.bvalid && s_axi_bready_in)
    begin
      nxt_st.bvalid = 1'b0;
    end

    if (s_axi_arvalid_in && !st_ff.rvalid)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = RESP_OKAY;
      nxt_st.rdata  = 8'h00;
      if (s_axi_araddr_in == ADDR_PROC_CLK_CTRL)
        nxt_st.rdata = pcc_view;
      else if (s_axi_araddr_in == ADDR_PROT_CMD)
        nxt_st.rdata = 8'h00;
      else if (s_axi_araddr_in == ADDR_INT_OSC_MODE)
        nxt_st.rdata = {7'h00, st_ff.int_halt};
      else if (s_axi_araddr_in == ADDR_STATUS)
        nxt_st.rdata = {7'h00, st_ff.int_osc};
      else
        nxt_st.rresp = RESP_SLVERR;
    end
    else if (st_ff.rvalid && s_axi_rready_in)
    begin
      nxt_st.rvalid = 1'b0;
    end

    case (st_ff.src)
      SRC_MAIN:
        if (st_ff.src_sel)
          nxt_st.src = SRC_TO_SUB;
      SRC_TO_SUB:
        if (!st_ff.src_sel)
          nxt_st.src = SRC_MAIN;
        else if (sub_tick)
          nxt_st.src = SRC_SUB;
      SRC_SUB:
        if (!st_ff.src_sel)
          nxt_st.src = SRC_TO_MAIN;
      SRC_TO_MAIN:
        if (st_ff.src_sel)
          nxt_st.src = SRC_SUB;
        else if (sub_tick)
          nxt_st.src = SRC_MAIN;
      default:
        nxt_st.src = SRC_MAIN;
    endcase

    // divide by 1 to 16; codes above 4 held at 16
    if (st_ff.div_sel > DIV_MAX_SEL)
      nxt_st.divide = 5'h10;
    else
      nxt_st.divide = 5'(5'h01 << st_ff.div_sel);

    // output flops follow next state so pins match the register view
    nxt_st.aw_rdy   = ~nxt_st.aw_got;
    nxt_st.w_rdy    = ~nxt_st.w_got;
    nxt_st.ar_rdy   = ~nxt_st.rvalid;
    nxt_st.sub_flag = (nxt_st.src == SRC_SUB) || (nxt_st.src == SRC_TO_MAIN);
    nxt_st.main_en  = ~nxt_st.main_stop;
    nxt_st.int_en   = ~(nxt_st.int_halt & ~nxt_st.int_osc);
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_ff         <= '0;
      st_ff.div_sel <= PCC_RESET[POS_DIV_HI:0];
      st_ff.src     <= SRC_MAIN;
      st_ff.divide  <= 5'h08;
      st_ff.aw_rdy  <= 1'b1;
      st_ff.w_rdy   <= 1'b1;
      st_ff.ar_rdy  <= 1'b1;
      st_ff.main_en <= 1'b1;
      st_ff.int_en  <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // outputs
  assign s_axi_awready_out    = st_ff.aw_rdy;
  assign s_axi_wready_out     = st_ff.w_rdy;
  assign s_axi_bvalid_out     = st_ff.bvalid;
  assign s_axi_bresp_out      = st_ff.bresp;
  assign s_axi_arready_out    = st_ff.ar_rdy;
  assign s_axi_rvalid_out     = st_ff.rvalid;
  assign s_axi_rdata_out      = {24'h000000, st_ff.rdata};
  assign s_axi_rresp_out      = st_ff.rresp;
  assign cpu_on_sub_clock_out = st_ff.sub_flag;
  assign main_osc_enable_out  = st_ff.main_en;
  assign int_osc_enable_out   = st_ff.int_en;
  assign clk_divide_out       = st_ff.divide;

endmodule // cpu_clock_source_switch

/* design/edge_sync.sv */
// two-stage synchroniser with rising edge pulse
`timescale 1ns/1ps
module edge_sync
(
  // clock and reset
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  // async level and its rising edge
  input  wire logic level_in,
  output logic      rise_out
);
  import clk_switch_pkg::*;

  typedef struct packed
  {
    logic [SYNC_STAGES-1:0] sync;
    logic                   last;
    logic                   rise;
  } sync_s;

  sync_s st_ff;
  sync_s nxt_st;

  // first stage feeds only the second stage
  always_comb
  begin
    nxt_st      = st_ff;
    nxt_st.sync = {st_ff.sync[SYNC_STAGES-2:0], level_in};
    nxt_st.last = st_ff.sync[SYNC_STAGES-1];
    nxt_st.rise = st_ff.sync[SYNC_STAGES-1] & ~st_ff.last;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign rise_out = st_ff.rise;

endmodule // edge_sync

/* tb/cpu_clock_source_switch_asserts.sv */
// concurrent checks on the cpu clock source switch ports
`timescale 1ns/1ps
module clk_switch_checker
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  // bus answers
  input  wire logic        s_axi_bvalid_out,
  input  wire logic        s_axi_arvalid_in,
  input  wire logic        s_axi_arready_out,
  input  wire logic        s_axi_rvalid_out,
  input  wire logic [31:0] s_axi_rdata_out,
  // clock sources and controls
  input  wire logic        sub_clock_in,
  input  wire logic        cpu_on_int_osc_in,
  input  wire logic        cpu_on_sub_clock_out,
  input  wire logic        main_osc_enable_out,
  input  wire logic        int_osc_enable_out,
  input  wire logic [4:0]  clk_divide_out
);
  // ======
  // helper: cycles since the last subclock rise
  logic [3:0] since_ff;
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      since_ff <= 4'hF;
    else if ($rose(sub_clock_in))
      since_ff <= 4'h0;
    else if (since_ff != 4'hF)
      since_ff <= since_ff + 4'h1;
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  // ======
  // checks
  AST_DIV_ONEHOT: assert property ($onehot(clk_divide_out))
    else $error("divisor not a power of two");
  AST_DIV_BY_WRITE: assert property ($changed(clk_divide_out) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out))
    else $error("divisor moved without a write");
  AST_OSC_BY_WRITE: assert property ($changed(main_osc_enable_out) |-> s_axi_bvalid_out || $past(s_axi_bvalid_out))
    else $error("main oscillator moved without a write");
  AST_SWITCH_ON_TICK: assert property ($changed(cpu_on_sub_clock_out) |-> since_ff <= 4'h8)
    else $error("source switched away from a subclock edge");
  AST_SWITCH_SETTLE: assert property ($changed(cpu_on_sub_clock_out) |=> $stable(cpu_on_sub_clock_out) [*8])
    else $error("source flag toggled twice");
  AST_INT_KEEP: assert property (cpu_on_int_osc_in [*5] |-> int_osc_enable_out)
    else $error("internal oscillator stopped under cpu");
  AST_UPPER_ZERO: assert property (s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0)
    else $error("upper read bits not zero");
  AST_READ_ANSWER: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read not answered next cycle");
  COV_TO_SUB: cover property ($rose(cpu_on_sub_clock_out));
  COV_TO_MAIN: cover property ($fell(cpu_on_sub_clock_out));
  COV_MAIN_STOP: cover property ($fell(main_osc_enable_out));
endmodule // clk_switch_checker

bind cpu_clock_source_switch clk_switch_checker chk_i (.*);

/* tb/cpu_clock_source_switch_tb.sv */
// register-level bench for the cpu clock source switch
`timescale 1ns/1ps
module cpu_clock_source_switch_tb;
  import clk_switch_pkg::*;
  logic        clk_in = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, sub = 1'b0, on_int = 1'b0;
  logic [3:0]  awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [1:0]  bresp, rresp;
  logic        awr, wrdy, bv, arr, rv, on_sub, main_en, int_en;
  logic [4:0]  div;
  int          err_count = 0, compares = 0, sc = 0;
  always #2 clk_in = ~clk_in;
  // 80-cycle subclock, five times slower than the clock divided by 16
  always @(posedge clk_in)
  begin
    sc <= (sc == 39) ? 0 : sc + 1;
    if (sc == 39)
      sub <= ~sub;
  end
  cpu_clock_source_switch uut (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .s_axi_awvalid_in(awv), .s_axi_awready_out(awr), .s_axi_awaddr_in(awa),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wrdy), .s_axi_wdata_in(wd),
    .s_axi_wstrb_in(4'h1), .s_axi_bvalid_out(bv), .s_axi_bready_in(1'b1),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arv), .s_axi_arready_out(arr),
    .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv), .s_axi_rready_in(1'b1),
    .s_axi_rdata_out(rdat), .s_axi_rresp_out(rresp), .sub_clock_in(sub),
    .cpu_on_int_osc_in(on_int), .cpu_on_sub_clock_out(on_sub),
    .main_osc_enable_out(main_en), .int_osc_enable_out(int_en), .clk_divide_out(div));
  task automatic results();
    $display("compares %0d errors %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // a used-up wait bound ends the run
  task automatic tmo(input int n);
    if (n >= 60)
    begin
      err_count++;
      results();
    end
  endtask
  task automatic bw(input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (awv && awr)
        awv <= 1'b0;
      if (wv && wrdy)
        wv <= 1'b0;
    end while (!bv && n < 60);
    tmo(n);
    chk("bresp", bresp, RESP_OKAY);
  endtask
  task automatic brd(input logic [3:0] a);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
      if (arv && arr)
        arv <= 1'b0;
    end while (!rv && n < 60);
    tmo(n);
    q = rdat;
  endtask
  // processor_clock_ctrl only moves right after an unlock
  task automatic pw(input logic [7:0] d);
    bw(ADDR_PROT_CMD, 8'h00);
    bw(ADDR_PROC_CLK_CTRL, d);
  endtask
  task automatic poll(input logic w);
    int n;
    n = 0;
    do
    begin
      brd(ADDR_PROC_CLK_CTRL);
      n++;
    end while (q[POS_SUB_ACTIVE] !== w && n < 60);
    tmo(n);
  endtask
  initial
  begin
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    brd(ADDR_PROC_CLK_CTRL);
    chk("ctrl", q, {24'h0, PCC_RESET});
    chk("rresp", rresp, RESP_OKAY);
    chk("div", div, 32'h8);
    brd(ADDR_INT_OSC_MODE);
    chk("osc_mode", q, 32'h0);
    brd(4'h2);
    chk("rresp_unmapped", rresp, RESP_SLVERR);
    chk("rdata_unmapped", q, 32'h0);
    $display("test reset done");
    for (int c = 0; c < 5; c++)
    begin
      pw(8'(c));
      @(posedge clk_in);
      chk("div", div, 32'(1 << c));
    end
    bw(ADDR_PROC_CLK_CTRL, 8'h00);
    brd(ADDR_PROC_CLK_CTRL);
    chk("locked", q, 32'h4);
    $display("test divider done");
    // divider bits stay at 4 across every switch
    pw(8'h0C);
    poll(1'b1);
    chk("on_sub", on_sub, 32'h1);
    // no pll or main-clock peripheral runs in this bench
    pw(8'h4C);
    @(posedge clk_in);
    chk("main_en", main_en, 32'h0);
    pw(8'h0C);
    @(posedge clk_in);
    chk("main_en", main_en, 32'h1);
    // settle the main oscillator before moving back onto it
    repeat (20) @(posedge clk_in);
    pw(8'h04);
    poll(1'b0);
    chk("on_sub", on_sub, 32'h0);
    pw(8'h14);
    brd(ADDR_PROC_CLK_CTRL);
    chk("flag_ro", q, 32'h4);
    $display("test switch done");
    on_int <= 1'b1;
    bw(ADDR_INT_OSC_MODE, 8'hFF);
    brd(ADDR_INT_OSC_MODE);
    chk("osc_mode", q, 32'h1);
    brd(ADDR_STATUS);
    chk("status", q, 32'h1);
    chk("int_en", int_en, 32'h1);
    on_int <= 1'b0;
    repeat (6) @(posedge clk_in);
    chk("int_en", int_en, 32'h0);
    bw(ADDR_INT_OSC_MODE, 8'h00);
    repeat (2) @(posedge clk_in);
    chk("int_en", int_en, 32'h1);
    $display("test internal osc done");
    results();
  end
endmodule // cpu_clock_source_switch_tb
